// file: rtl/anp_pkg.sv
/*
 * Shared constants and types for the auto-negotiation next-page register
 * block: register indices and byte addresses, reset values, field masks,
 * the next-page word layout and the bus state encodings.
 * Assumes a 32-bit AXI4-Lite register bus with one word per register.
 */
package anp_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] LOCAL_IDX = 8'h07;
   localparam logic [7:0] PARTNER_IDX = 8'h08;
   localparam logic [7:0] STATUS_IDX = 8'h10;
   // byte address is four times the index
   localparam logic [7:0] LOCAL_ADDR = {LOCAL_IDX[5:0], 2'b00};
   localparam logic [7:0] PARTNER_ADDR = {PARTNER_IDX[5:0], 2'b00};
   localparam logic [7:0] STATUS_ADDR = {STATUS_IDX[5:0], 2'b00};

   // ------------------------------------------------------------------
   // reset values and field masks
   // ------------------------------------------------------------------
   localparam logic [15:0] LOCAL_RESET = 16'h2001;
   localparam logic [15:0] PARTNER_RESET = 16'h0000;
   localparam logic [15:0] LOCAL_WR_MASK = 16'hB7FF;
   localparam logic [2:0] STATUS_RESET = 3'h0;
   localparam int unsigned ST_RCVD_BIT = 0;
   localparam int unsigned ST_SENT_BIT = 1;
   localparam int unsigned ST_PEND_BIT = 2;

   // ------------------------------------------------------------------
   // bus answers
   // ------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   // one next-page link code word, bit 15 first
   typedef struct packed {
      logic more;
      logic ack;
      logic msg;
      logic ack2;
      logic toggle;
      logic [10:0] code;
   } anp_page_t;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP = 2'b10
   } anp_wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } anp_rd_state_t;

endpackage

// file: rtl/anp_toggle_track.sv
/*
 * Toggle tracker for outgoing next pages: holds the toggle bit that the
 * next transmitted page carries.
 * Assumes page_sent is a one-cycle pulse on aclk per exchanged page.
 */
module anp_toggle_track (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic page_sent,
   output logic toggle
);

   // each exchange flips the bit, so the next word carries the inverse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         toggle <= 1'b0;
      end else if (page_sent) begin
         toggle <= ~toggle;
      end
   end

endmodule

// file: rtl/anp_partner_capture.sv
/*
 * Capture of the next page received from the link partner, with a sticky
 * page-received flag.
 * Assumes page_rcvd is a one-cycle pulse on aclk with rx_page valid then.
 */
module anp_partner_capture (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic page_rcvd,
   input wire anp_pkg::anp_page_t rx_page,
   input wire logic clear_rcvd,
   output anp_pkg::anp_page_t partner,
   output logic rcvd_flag
);

   // whole word taken at once so fields never mix two pages
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         partner <= anp_pkg::PARTNER_RESET;
      end else if (page_rcvd) begin
         partner <= rx_page;
      end
   end

   // a page arriving during the clear keeps the flag set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rcvd_flag <= 1'b0;
      end else if (page_rcvd) begin
         rcvd_flag <= 1'b1;
      end else if (clear_rcvd) begin
         rcvd_flag <= 1'b0;
      end
   end

endmodule

// file: rtl/anp_next_page_regs.sv
/*
 * Auto-negotiation next-page registers: the local next-page word that
 * software loads for transmission, the captured partner next page, and a
 * status word, all behind an AXI4-Lite slave.
 * Assumes the auto-negotiation engine runs on aclk, pulses an_page_sent
 * once per exchanged local page and an_page_rcvd once per received page.
 */

module anp_next_page_regs (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address channel
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // auto-negotiation engine side
   input wire logic an_page_sent,
   input wire logic an_page_rcvd,
   input wire anp_pkg::anp_page_t an_rx_page,
   output anp_pkg::anp_page_t an_tx_page,
   output logic an_tx_pending
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   anp_pkg::anp_wr_state_t wr_state;
   anp_pkg::anp_wr_state_t next_wr_state;
   anp_pkg::anp_rd_state_t rd_state;
   anp_pkg::anp_rd_state_t next_rd_state;

   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   logic [15:0] local_store;
   logic toggle;
   anp_pkg::anp_page_t partner;
   logic rcvd_flag;
   logic sent_flag;
   logic pending;

   wire aw_take;
   wire w_take;
   wire do_write;
   wire [7:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire wr_hit_local;
   wire wr_hit_status;
   wire wr_mapped;
   wire [15:0] lane_mask;
   wire [15:0] local_wmask;
   wire [15:0] next_local;
   wire clear_rcvd;
   wire clear_sent;

   wire ar_take;
   wire rd_hit_local;
   wire rd_hit_partner;
   wire rd_hit_status;
   wire rd_mapped;
   wire [15:0] local_view;
   wire [2:0] status_view;
   wire [31:0] rd_word;

   // ------------------------------------------------------------------
   // write channels
   // ------------------------------------------------------------------
   // address and data are taken independently, in either order
   assign s_axi_awready = (wr_state == anp_pkg::WR_COLLECT) && !aw_held;
   assign s_axi_wready = (wr_state == anp_pkg::WR_COLLECT) && !w_held;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;

   // the write commits in the cycle both halves are present
   assign do_write = (wr_state == anp_pkg::WR_COLLECT)
                     && (aw_held || aw_take) && (w_held || w_take);
   assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   assign wr_data = w_held ? w_data : s_axi_wdata;
   assign wr_strb = w_held ? w_strb : s_axi_wstrb;

   // low two address bits are ignored, registers are whole words
   assign wr_hit_local = wr_addr[7:2] == anp_pkg::LOCAL_ADDR[7:2];
   assign wr_hit_status = wr_addr[7:2] == anp_pkg::STATUS_ADDR[7:2];
   assign wr_mapped = wr_hit_local || wr_hit_status
                      || (wr_addr[7:2] == anp_pkg::PARTNER_ADDR[7:2]);

   // byte lanes 0 and 1 cover the 16-bit word, upper lanes have no storage
   assign lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   // toggle and reserved bit are not writable
   assign local_wmask = lane_mask & anp_pkg::LOCAL_WR_MASK;
   assign next_local = (local_store & ~local_wmask)
                       | (wr_data[15:0] & local_wmask);

   // write-one-to-clear on the sticky status bits
   assign clear_rcvd = do_write && wr_hit_status && wr_strb[0]
                       && wr_data[anp_pkg::ST_RCVD_BIT];
   assign clear_sent = do_write && wr_hit_status && wr_strb[0]
                       && wr_data[anp_pkg::ST_SENT_BIT];

   // write state sequencing
   always_comb begin
      next_wr_state = wr_state;
      case (wr_state)
         anp_pkg::WR_COLLECT: begin
            if (do_write) begin
               next_wr_state = anp_pkg::WR_RESP;
            end
         end
         anp_pkg::WR_RESP: begin
            if (s_axi_bready) begin
               next_wr_state = anp_pkg::WR_COLLECT;
            end
         end
         default: begin
            next_wr_state = anp_pkg::WR_COLLECT;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= anp_pkg::WR_COLLECT;
      end else begin
         wr_state <= next_wr_state;
      end
   end

   // hold whichever half arrives first until its partner shows up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else if (aw_take) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (do_write) begin
         w_held <= 1'b0;
      end else if (w_take) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
   end

   // response registered with the commit; unmapped words answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bresp <= anp_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bresp <= wr_mapped ? anp_pkg::RESP_OKAY
                                  : anp_pkg::RESP_SLVERR;
      end
   end

   // answer stands until the master raises bready
   assign s_axi_bvalid = wr_state == anp_pkg::WR_RESP;

   // ------------------------------------------------------------------
   // local next-page word
   // ------------------------------------------------------------------
   // reset advertises a null message page with no further pages
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         local_store <= anp_pkg::LOCAL_RESET;
      end else if (do_write && wr_hit_local) begin
         local_store <= next_local;
      end
   end

   anp_toggle_track u_toggle (
      .aclk(aclk),
      .aresetn(aresetn),
      .page_sent(an_page_sent),
      .toggle(toggle)
   );

   // software view: toggle from the tracker, reserved bit forced low
   assign local_view = {local_store[15], 1'b0, local_store[13:12],
                        toggle, local_store[10:0]};

   // word handed to the engine lags the register by one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         an_tx_page <= anp_pkg::LOCAL_RESET;
      end else begin
         an_tx_page <= local_view;
      end
   end

   // pending: a word was loaded and not yet exchanged; a write that
   // meets the exchange edge was not the word sent, so it stays pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending <= 1'b0;
      end else if (do_write && wr_hit_local) begin
         pending <= 1'b1;
      end else if (an_page_sent) begin
         pending <= 1'b0;
      end
   end

   // level to the engine: a fresh word is waiting to go out
   assign an_tx_pending = pending;

   // ------------------------------------------------------------------
   // partner page and status
   // ------------------------------------------------------------------
   anp_partner_capture u_capture (
      .aclk(aclk),
      .aresetn(aresetn),
      .page_rcvd(an_page_rcvd),
      .rx_page(an_rx_page),
      .clear_rcvd(clear_rcvd),
      .partner(partner),
      .rcvd_flag(rcvd_flag)
   );

   // sticky exchange flag, a new exchange beats the software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sent_flag <= 1'b0;
      end else if (an_page_sent) begin
         sent_flag <= 1'b1;
      end else if (clear_sent) begin
         sent_flag <= 1'b0;
      end
   end

   // status word packs the three flags, received in bit 0
   assign status_view = {pending, sent_flag, rcvd_flag};

   // ------------------------------------------------------------------
   // read channels
   // ------------------------------------------------------------------
   // one read in flight; a new address waits while data stands
   assign s_axi_arready = rd_state == anp_pkg::RD_IDLE;
   assign ar_take = s_axi_arvalid && s_axi_arready;

   // decode on the word index, byte offset bits dropped
   assign rd_hit_local = s_axi_araddr[7:2] == anp_pkg::LOCAL_ADDR[7:2];
   assign rd_hit_partner =
      s_axi_araddr[7:2] == anp_pkg::PARTNER_ADDR[7:2];
   assign rd_hit_status = s_axi_araddr[7:2] == anp_pkg::STATUS_ADDR[7:2];
   assign rd_mapped = rd_hit_local || rd_hit_partner || rd_hit_status;

   // upper bits of every word read as zero
   assign rd_word = rd_hit_local ? {16'h0000, local_view}
                  : rd_hit_partner ? {16'h0000, partner}
                  : rd_hit_status ? {29'h0000_0000, status_view}
                  : 32'h0000_0000;

   // read state sequencing
   always_comb begin
      next_rd_state = rd_state;
      case (rd_state)
         anp_pkg::RD_IDLE: begin
            if (ar_take) begin
               next_rd_state = anp_pkg::RD_DATA;
            end
         end
         anp_pkg::RD_DATA: begin
            if (s_axi_rready) begin
               next_rd_state = anp_pkg::RD_IDLE;
            end
         end
         default: begin
            next_rd_state = anp_pkg::RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= anp_pkg::RD_IDLE;
      end else begin
         rd_state <= next_rd_state;
      end
   end

   // data sampled at the address edge and held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= anp_pkg::RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_mapped ? anp_pkg::RESP_OKAY
                                  : anp_pkg::RESP_SLVERR;
      end
   end

   // read answer stands until rready is seen
   assign s_axi_rvalid = rd_state == anp_pkg::RD_DATA;

endmodule

// file: verification/anp_regs_sva.sv
/*
 * Port checker for the next-page register block.
 * Assumes it is bound onto anp_next_page_regs, one clock aclk.
 */
module anp_regs_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic an_page_sent,
   input wire anp_pkg::anp_page_t an_tx_page,
   input wire logic an_tx_pending
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // any handshake that could commit a write this cycle
   logic wr_hs;
   logic ev;
   assign wr_hs = (s_axi_awvalid && s_axi_awready) ||
                  (s_axi_wvalid && s_axi_wready);
   assign ev = wr_hs || an_page_sent;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   a_tx_reserved_zero: assert property (
      an_tx_page.ack == 1'b0) else $error("reserved bit set");
   a_reset_word: assert property (
      $rose(aresetn) |-> an_tx_page == anp_pkg::LOCAL_RESET
      && !an_tx_pending) else $error("bad local reset word");
   // a word only moves two cycles after a write or an exchange
   a_tx_stable: assert property (
      !ev |-> ##2 $stable(an_tx_page)) else $error("word moved");
   a_toggle_flip: assert property (
      an_page_sent ##1 !an_page_sent |=> an_tx_page.toggle !=
      $past(an_tx_page.toggle)) else $error("toggle not flipped");
   a_pending_clear: assert property (
      an_page_sent && !wr_hs |=> !an_tx_pending)
      else $error("pending stuck");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
      $stable(s_axi_bresp)) else $error("write answer dropped");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
      $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped");
   a_read_latency: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule

bind anp_next_page_regs anp_regs_sva chk_u (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .an_page_sent, .an_tx_page, .an_tx_pending);

// file: verification/anp_engine_model.sv
/*
 * Behavioural auto-negotiation engine facing the register block.
 * Assumes the bench asks for one page event at a time on aclk.
 */
module anp_engine_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req,
   input wire logic [1:0] kind,
   input wire logic [3:0] dly,
   input wire anp_pkg::anp_page_t page,
   output logic an_page_sent,
   output logic an_page_rcvd,
   output anp_pkg::anp_page_t an_rx_page
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // page event after a chosen delay
   // ---------------------------------------------------------------
   logic busy;
   logic [3:0] cnt;
   logic [1:0] k;
   anp_pkg::anp_page_t held;
   // outside a pulse the word churns so stale data is never trusted
   always_ff @(posedge aclk) begin
      an_page_sent <= 1'b0;
      an_page_rcvd <= 1'b0;
      an_rx_page <= ~an_rx_page;
      if (!aresetn) begin
         busy <= 1'b0;
         an_rx_page <= 16'h0000;
      end else if (req && !busy) begin
         busy <= 1'b1;
         cnt <= dly;
         k <= kind;
         held <= page;
      end else if (busy && cnt == 4'h0) begin
         busy <= 1'b0;
         an_rx_page <= held;
         an_page_rcvd <= k[0];
         an_page_sent <= k[1];
      end else if (busy) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule

// file: verification/autoneg_next_page_regs_test.sv
/*
 * Self-checking bench for the next-page register block.
 * Assumes the bound checker and the engine model beside the design.
 */
module autoneg_next_page_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic an_page_sent, an_page_rcvd, an_tx_pending;
   anp_pkg::anp_page_t an_rx_page, an_tx_page;
   anp_pkg::anp_page_t m_page = 16'h0;
   logic m_req = 1'b0;
   logic [1:0] m_kind = 2'h0;
   logic [3:0] m_dly = 4'h0;
   int n_fail = 0;
   int compares = 0;
   int i;
   logic [15:0] loc;
   logic [31:0] d;
   logic [3:0] s;
   logic tgl;

   always #4 aclk = ~aclk;

   anp_next_page_regs dut_u (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .an_page_sent, .an_page_rcvd,
      .an_rx_page, .an_tx_page, .an_tx_pending);
   anp_engine_model eng_u (.aclk, .aresetn, .req(m_req), .kind(m_kind),
      .dly(m_dly), .page(m_page), .an_page_sent, .an_page_rcvd,
      .an_rx_page);

   // ---------------------------------------------------------------
   // tasks and expectations
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // lane masks limited to the writable bits, toggle put back in
   function automatic logic [15:0] exp_local(logic [15:0] o,
      logic [31:0] dd, logic [3:0] ss, logic t);
      logic [15:0] m;
      m = {{8{ss[1]}}, {8{ss[0]}}} & anp_pkg::LOCAL_WR_MASK;
      return (((o & ~m) | (dd[15:0] & m)) & 16'hF7FF) | {4'h0, t, 11'h0};
   endfunction
   // bready may lag a little so stalled answers are exercised
   task automatic axw(input logic [7:0] a, input logic [31:0] dd,
      input logic [3:0] ss, input logic [1:0] er);
      int n;
      bit aw_d, w_d;
      aw_d = 0;
      w_d = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= dd;
      s_axi_wstrb <= ss;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'($urandom % 2);
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (!aw_d && s_axi_awready) aw_d = 1;
         if (!w_d && s_axi_wready) w_d = 1;
         if (aw_d) s_axi_awvalid <= 1'b0;
         if (w_d) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      if (n == 50) begin
         n_fail++;
         print_verdict();
      end
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] ex,
      input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'($urandom % 2);
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      if (n == 50) begin
         n_fail++;
         print_verdict();
      end
      chk("rdata", s_axi_rdata, ex);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   task automatic page_ev(input logic [1:0] k, input logic [15:0] p);
      int n;
      m_page <= p;
      m_kind <= k;
      m_dly <= 4'($urandom % 6);
      m_req <= 1'b1;
      @(posedge aclk);
      m_req <= 1'b0;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (an_page_sent || an_page_rcvd) break;
      end
      if (n == 40) begin
         n_fail++;
         print_verdict();
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(75));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axr(anp_pkg::LOCAL_ADDR, 32'h2001, 2'h0);
      axr(anp_pkg::PARTNER_ADDR, 32'h0, 2'h0);
      axr(anp_pkg::STATUS_ADDR, 32'h0, 2'h0);
      $display("test reset_values done");
      loc = 16'h2001;
      tgl = 1'b0;
      for (i = 0; i < 12; i++) begin
         d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $urandom;
         s = (i < 2) ? 4'hF : 4'($urandom);
         axw(anp_pkg::LOCAL_ADDR, d, s, 2'h0);
         loc = exp_local(loc, d, s, tgl);
         @(posedge aclk);
         chk("tx_page", an_tx_page, {16'h0, loc});
         chk("pending", an_tx_pending, 32'h1);
         axr(anp_pkg::LOCAL_ADDR, {16'h0, loc}, 2'h0);
         axr(anp_pkg::STATUS_ADDR, (i == 0) ? 32'h4 : 32'h6, 2'h0);
         // exchange before the next load, as software must
         page_ev(2'h2, 16'($urandom));
         tgl = ~tgl;
         loc[11] = tgl;
      end
      $display("test local_writes done");
      for (i = 0; i < 3; i++) begin
         page_ev((i == 2) ? 2'h3 : 2'h2, 16'($urandom));
         tgl = ~tgl;
         loc[11] = tgl;
         axr(anp_pkg::LOCAL_ADDR, {16'h0, loc}, 2'h0);
         chk("pending", an_tx_pending, 32'h0);
      end
      axw(anp_pkg::STATUS_ADDR, 32'h3, 4'h1, 2'h0);
      axr(anp_pkg::STATUS_ADDR, 32'h0, 2'h0);
      $display("test toggle done");
      for (i = 0; i < 5; i++) begin
         d = (i == 0) ? 32'hFFFF : $urandom;
         page_ev(2'h1, d[15:0]);
         axr(anp_pkg::PARTNER_ADDR, {16'h0, d[15:0]}, 2'h0);
         axw(anp_pkg::PARTNER_ADDR, ~d, 4'hF, 2'h0);
         axr(anp_pkg::PARTNER_ADDR, {16'h0, d[15:0]}, 2'h0);
      end
      axr(anp_pkg::STATUS_ADDR, 32'h1, 2'h0);
      $display("test partner done");
      axw(8'h30, 32'hFFFF, 4'hF, anp_pkg::RESP_SLVERR);
      axr(8'h30, 32'h0, anp_pkg::RESP_SLVERR);
      axr(anp_pkg::LOCAL_ADDR, {16'h0, loc}, 2'h0);
      $display("test unmapped done");
      print_verdict();
   end
endmodule
